// ===== rtl/ecc_eeprom_command_control.sv
// eeprom command/handshake register block with apb slave and interrupt
`timescale 1ns/10ps

// Summary of operation
// - writing busy one starts the selected command
// - busy stays set until the operation completes
// - busy clear after read means data valid
// - missing eeprom: busy clears when timeout sets
// - busy set after power-up, pin, soft reset
// - busy clears when the configuration loader finishes
// - opcode bits 30:28, reset 000, 000 is read
module ecc_eeprom_command_control #(
	parameter int unsigned TIMEOUT_CYCLES = ecc_pkg::ECC_TIMEOUT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ecc_pkg::ECC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic soft_reset,
	input wire logic loader_done,
	output ecc_pkg::ecc_op_req_t op_req,
	input wire logic op_done,
	input wire logic [31:0] op_rdata,
	output logic irq
);
	import ecc_pkg::*;

	localparam logic [ECC_TMO_W-1:0] TMO_LAST =
		ECC_TMO_W'(TIMEOUT_CYCLES - 1);

	ecc_regs_t r;
	ecc_regs_t next_r;
	logic setup;
	logic access;
	logic wr_cmd;
	logic wr_data;
	logic wr_mask;
	logic rd_stat;
	logic [ECC_EV_W-1:0] events;

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_cmd = access & pwrite & (paddr == ECC_CMD_OFS);
	assign wr_data = access & pwrite & (paddr == ECC_DATA_OFS);
	assign wr_mask = access & pwrite & (paddr == ECC_MASK_OFS);
	assign rd_stat = access & ~pwrite & (paddr == ECC_STAT_OFS);

	always_comb begin
		next_r = r;
		next_r.start = 1'b0;
		events = '0;
		// read data sampled in setup so prdata comes from a flop
		if (setup) begin
			next_r.pslverr = 1'b0;
			unique case (paddr)
				ECC_CMD_OFS: next_r.prdata = {r.busy, r.opcode,
					ECC_CMD_RSVD, r.eaddr};
				ECC_DATA_OFS: next_r.prdata = r.data;
				ECC_STAT_OFS: next_r.prdata = {ECC_STAT_RSVD, r.status};
				ECC_MASK_OFS: next_r.prdata = {ECC_STAT_RSVD, r.mask};
				default: begin
					next_r.prdata = '0;
					next_r.pslverr = 1'b1;
				end
			endcase
		end
		unique case (r.st)
			ECC_LOAD: begin
				if (loader_done) begin
					next_r.busy = 1'b0;
					next_r.st = ECC_IDLE;
				end
			end
			ECC_IDLE: begin
				// command and data writes only take effect while idle
				if (wr_cmd) begin
					next_r.opcode = pwdata[ECC_OPC_HI:ECC_OPC_LO];
					next_r.eaddr = pwdata[ECC_EADDR_HI:ECC_EADDR_LO];
					if (pwdata[ECC_BUSY_BIT]) begin
						next_r.busy = 1'b1;
						next_r.start = 1'b1;
						next_r.tmo_cnt = '0;
						next_r.st = ECC_RUN;
					end
				end
				if (wr_data) begin
					next_r.data = pwdata;
				end
			end
			ECC_RUN: begin
				// command and data writes while busy are dropped; mask writes still apply
				next_r.tmo_cnt = r.tmo_cnt + 1'b1;
				if (op_done) begin
					next_r.busy = 1'b0;
					next_r.st = ECC_IDLE;
					events[ECC_EV_DONE] = 1'b1;
					if (r.opcode == ECC_OPC_READ) begin
						next_r.data = op_rdata;
					end
				end else if (r.tmo_cnt == TMO_LAST) begin
					// no eeprom answer: clear busy with the timeout flag
					next_r.busy = 1'b0;
					next_r.st = ECC_IDLE;
					events[ECC_EV_TMO] = 1'b1;
				end
			end
		endcase
		if (wr_mask) begin
			next_r.mask = pwdata[ECC_EV_W-1:0];
		end
		// read clears only the bits it returned; a later event survives
		if (rd_stat) begin
			next_r.status = next_r.status & ~r.prdata[ECC_EV_W-1:0];
		end
		next_r.status = next_r.status | events;
		// soft reset restarts the loader wait and resets opcode; other bus-side registers kept
		if (soft_reset) begin
			next_r.st = ECC_LOAD;
			next_r.busy = 1'b1;
			next_r.opcode = ECC_OPC_RESET;
			next_r.start = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.st <= ECC_LOAD;
			r.busy <= 1'b1;
			r.opcode <= ECC_OPC_RESET;
			r.eaddr <= '0;
			r.data <= '0;
			r.status <= '0;
			r.mask <= '0;
			r.tmo_cnt <= '0;
			r.prdata <= '0;
			r.pslverr <= 1'b0;
			r.start <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// zero wait states: access phase always completes
	assign pready = access;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr & access;
	assign irq = |(r.status & r.mask);
	assign op_req.start = r.start;
	assign op_req.opcode = r.opcode;
	assign op_req.addr = r.eaddr;
	assign op_req.wdata = r.data;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_start_sets_busy;
		(r.st == ECC_IDLE) && wr_cmd && pwdata[ECC_BUSY_BIT] && !soft_reset
			|=> r.busy && op_req.start && (r.st == ECC_RUN);
	endproperty
	a_start_sets_busy: assert property (p_start_sets_busy)
		else $error("go write did not start operation");

	property p_busy_holds;
		(r.st == ECC_RUN) && !op_done && (r.tmo_cnt != TMO_LAST)
			&& !soft_reset |=> r.busy;
	endproperty
	a_busy_holds: assert property (p_busy_holds)
		else $error("busy dropped before operation end");

	property p_read_data;
		(r.st == ECC_RUN) && op_done && (r.opcode == ECC_OPC_READ)
			&& !soft_reset |=> !r.busy && (r.data == $past(op_rdata));
	endproperty
	a_read_data: assert property (p_read_data)
		else $error("read data not valid when busy cleared");

	property p_busy_cmd_stable;
		(r.st == ECC_RUN) && !soft_reset |=> $stable(r.opcode)
			&& $stable(r.eaddr);
	endproperty
	a_busy_cmd_stable: assert property (p_busy_cmd_stable)
		else $error("command changed while busy");

	property p_timeout;
		(r.st == ECC_RUN) && !op_done && (r.tmo_cnt == TMO_LAST)
			&& !soft_reset |=> !r.busy && r.status[ECC_EV_TMO];
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout did not clear busy");

	property p_soft_reset;
		soft_reset |=> r.busy && (r.st == ECC_LOAD)
			##1 (r.busy || ($past(loader_done) && !$past(soft_reset)));
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("busy not set after soft reset");

	property p_loader_done;
		(r.st == ECC_LOAD) && loader_done && !soft_reset
			|=> !r.busy && (r.st == ECC_IDLE);
	endproperty
	a_loader_done: assert property (p_loader_done)
		else $error("busy not cleared after loader");

	property p_start_busy;
		op_req.start |-> r.busy && $rose(r.busy);
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("command issued without busy");

	// state and flag consistency around the busy handshake
	property p_load_busy;
		(r.st == ECC_LOAD) |-> r.busy;
	endproperty
	a_load_busy: assert property (p_load_busy)
		else $error("busy low while loader runs");

	property p_idle_free;
		(r.st == ECC_IDLE) |-> !r.busy;
	endproperty
	a_idle_free: assert property (p_idle_free)
		else $error("busy high while idle");

	property p_run_busy;
		(r.st == ECC_RUN) |-> r.busy;
	endproperty
	a_run_busy: assert property (p_run_busy)
		else $error("busy low while operation runs");

	property p_start_pulse;
		op_req.start |=> !op_req.start;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start held longer than one cycle");

	property p_go_zero;
		(r.st == ECC_IDLE) && wr_cmd && !pwdata[ECC_BUSY_BIT] && !soft_reset
			|=> !r.busy && !op_req.start && (r.st == ECC_IDLE);
	endproperty
	a_go_zero: assert property (p_go_zero)
		else $error("command write without go started operation");

	property p_write_data_idle;
		(r.st == ECC_IDLE) && wr_data && !soft_reset
			|=> (r.data == $past(pwdata));
	endproperty
	a_write_data_idle: assert property (p_write_data_idle)
		else $error("data write while idle not stored");

	property p_busy_data_kept;
		(r.st == ECC_RUN) && !op_done |=> $stable(r.data);
	endproperty
	a_busy_data_kept: assert property (p_busy_data_kept)
		else $error("data register changed while busy");

	property p_done_flag;
		(r.st == ECC_RUN) && op_done && !soft_reset
			|=> !r.busy && r.status[ECC_EV_DONE];
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("done flag not set at operation end");

	property p_read_clear;
		rd_stat && (r.st != ECC_RUN)
			&& (r.prdata[ECC_EV_W-1:0] == r.status) |=> (r.status == '0);
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("status not cleared by read");

	property p_irq_done_on;
		r.status[ECC_EV_DONE] && r.mask[ECC_EV_DONE] |-> irq;
	endproperty
	a_irq_done_on: assert property (p_irq_done_on)
		else $error("unmasked done flag without interrupt");

	property p_irq_tmo_off;
		r.status[ECC_EV_TMO] && !r.mask[ECC_EV_TMO]
			&& !(r.status[ECC_EV_DONE] && r.mask[ECC_EV_DONE]) |-> !irq;
	endproperty
	a_irq_tmo_off: assert property (p_irq_tmo_off)
		else $error("masked timeout flag raised interrupt");

	property p_unmapped;
		setup && (paddr != ECC_CMD_OFS) && (paddr != ECC_DATA_OFS)
			&& (paddr != ECC_STAT_OFS) && (paddr != ECC_MASK_OFS)
			|=> r.pslverr && (r.prdata == '0);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped address not refused");

	c_read_done: cover property ((r.st == ECC_RUN) && op_done
		&& (r.opcode == ECC_OPC_READ));
	c_timeout: cover property ((r.st == ECC_RUN)
		&& (r.tmo_cnt == TMO_LAST) && !op_done);
	c_loader: cover property ((r.st == ECC_LOAD) && loader_done);
	c_irq: cover property ($rose(irq));
	c_soft_reset: cover property (soft_reset && (r.st == ECC_IDLE));
endmodule // ecc_eeprom_command_control

// ===== rtl/ecc_pkg.sv
// shared constants and types for the eeprom command control block
package ecc_pkg;
	localparam int ECC_ADDR_W = 12;
	localparam int ECC_EE_ADDR_W = 16;
	localparam int ECC_TMO_W = 16;

	// register byte addresses
	localparam logic [ECC_ADDR_W-1:0] ECC_CMD_OFS = 12'h1B4;
	localparam logic [ECC_ADDR_W-1:0] ECC_DATA_OFS = 12'h1B8;
	localparam logic [ECC_ADDR_W-1:0] ECC_STAT_OFS = 12'h1C0;
	localparam logic [ECC_ADDR_W-1:0] ECC_MASK_OFS = 12'h1C4;

	// command register fields
	localparam int ECC_BUSY_BIT = 31;
	localparam int ECC_OPC_HI = 30;
	localparam int ECC_OPC_LO = 28;
	localparam int ECC_EADDR_HI = 15;
	localparam int ECC_EADDR_LO = 0;
	localparam logic [11:0] ECC_CMD_RSVD = 12'h000;

	// opcodes
	localparam logic [2:0] ECC_OPC_READ = 3'h0;
	localparam logic [2:0] ECC_OPC_RESET = 3'h0;

	// interrupt status / mask bits
	localparam int ECC_EV_W = 2;
	localparam int ECC_EV_DONE = 0;
	localparam int ECC_EV_TMO = 1;
	localparam logic [29:0] ECC_STAT_RSVD = 30'h00000000;

	// timing
	localparam int ECC_CLK_MHZ = 250;
	localparam int ECC_TIMEOUT_US = 30;
	localparam int ECC_TIMEOUT_CYC = ECC_TIMEOUT_US * ECC_CLK_MHZ;

	typedef enum logic [1:0] {
		ECC_LOAD,
		ECC_IDLE,
		ECC_RUN
	} ecc_state_t;

	// request toward the serial eeprom engine
	typedef struct packed {
		logic start;
		logic [2:0] opcode;
		logic [ECC_EE_ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} ecc_op_req_t;

	typedef struct packed {
		ecc_state_t st;
		logic busy;
		logic [2:0] opcode;
		logic [ECC_EE_ADDR_W-1:0] eaddr;
		logic [31:0] data;
		logic [ECC_EV_W-1:0] status;
		logic [ECC_EV_W-1:0] mask;
		logic [ECC_TMO_W-1:0] tmo_cnt;
		logic [31:0] prdata;
		logic pslverr;
		logic start;
	} ecc_regs_t;
endpackage

// ===== verif/ecc_eeprom_command_control_tb.sv
// self-checking bench for the eeprom command control block
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module ecc_eeprom_command_control_tb;
	import ecc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ECC_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, op_rdata;
	logic pready, pslverr, err, op_done, irq;
	logic soft_reset = 0, loader_done = 0, no_dev = 0;
	ecc_op_req_t op_req;
	int n_mismatch = 0, tests_run = 0, p;
	ecc_eeprom_command_control #(.TIMEOUT_CYCLES(20)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .soft_reset(soft_reset),
		.loader_done(loader_done), .op_req(op_req), .op_done(op_done),
		.op_rdata(op_rdata), .irq(irq));
	ecc_engine_model eng (.pclk(pclk), .presetn(presetn), .op_req(op_req),
		.no_dev(no_dev), .op_done(op_done), .op_rdata(op_rdata));
	initial begin
		forever #2 pclk = ~pclk;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 50) begin n_mismatch++; report_and_stop(); end
	endtask
	// poll until idle; bounded so a stuck busy ends the run
	task automatic wait_idle;
		p = 0;
		do begin
			apb(0, ECC_CMD_OFS, '0);
			p++;
		end while (rd[ECC_BUSY_BIT] !== 1'h0 && p < 40);
		if (p >= 40) begin n_mismatch++; report_and_stop(); end
	endtask
	task automatic load_done;
		apb(0, ECC_CMD_OFS, '0);
		`CHK(rd[ECC_BUSY_BIT], 1'h1)
		`CHK(rd[30:28], 3'h0)
		@(posedge pclk);
		loader_done <= 1;
		@(posedge pclk);
		loader_done <= 0;
		wait_idle();
	endtask
	task automatic t_read(input logic [15:0] ea);
		apb(1, ECC_MASK_OFS, 32'h1);
		apb(1, ECC_CMD_OFS, {16'h0, ea});
		apb(0, ECC_CMD_OFS, '0);
		`CHK(rd, {16'h0, ea})
		apb(1, ECC_CMD_OFS, {1'h1, ECC_OPC_READ, 12'h0, ea});
		apb(0, ECC_CMD_OFS, '0);
		`CHK(rd[ECC_BUSY_BIT], 1'h1)
		`CHK(op_req.addr, ea)
		wait_idle();
		apb(0, ECC_DATA_OFS, '0);
		`CHK(rd, {16'hA5C3, ea})
		`CHK(irq, 1'h1)
		apb(0, ECC_STAT_OFS, '0);
		`CHK(rd[1:0], 2'h1)
		@(negedge pclk);
		`CHK(irq, 1'h0)
	endtask
	task automatic t_timeout;
		no_dev <= 1;
		apb(1, ECC_DATA_OFS, 32'h5A5A1234);
		apb(1, ECC_CMD_OFS, {1'h1, 3'h3, 12'h0, 16'h0040});
		apb(0, ECC_DATA_OFS, '0);
		`CHK(rd, 32'h5A5A1234)
		`CHK(op_req.opcode, 3'h3)
		`CHK(op_req.wdata, 32'h5A5A1234)
		wait_idle();
		`CHK(p, 7)
		apb(0, ECC_STAT_OFS, '0);
		`CHK(rd[1:0], 2'h2)
		`CHK(irq, 1'h0)
		no_dev <= 0;
	endtask
	task automatic t_soft;
		@(posedge pclk);
		soft_reset <= 1;
		@(posedge pclk);
		soft_reset <= 0;
		load_done();
	endtask
	task automatic t_pin_reset;
		@(posedge pclk);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		load_done();
	endtask
	task automatic t_unmapped;
		apb(0, 12'h1BC, '0);
		`CHK(err, 1'h1)
		`CHK(rd, 32'h0)
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		load_done();
		t_read(16'h0123);
		t_timeout();
		t_soft();
		t_unmapped();
		t_pin_reset();
		t_read(16'h0456);
		report_and_stop();
	end
endmodule // ecc_eeprom_command_control_tb

// ===== verif/ecc_engine_model.sv
// behavioural serial eeprom engine facing the command block
`timescale 1ns/10ps
module ecc_engine_model #(
	parameter int DELAY = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire ecc_pkg::ecc_op_req_t op_req,
	input wire logic no_dev,
	output logic op_done,
	output logic [31:0] op_rdata
);
	import ecc_pkg::*;
	int cnt;
	logic [31:0] last;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			op_done <= 1'h0;
			last <= 32'h0;
		end else begin
			op_done <= 1'h0;
			// absent device never answers, block must time out
			if (op_req.start && !no_dev) begin
				cnt <= DELAY;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					op_done <= 1'h1;
					// result tied to the addressed word
					last <= {16'hA5C3, op_req.addr};
				end
			end
		end
	end
	// outside the done pulse the bus shows junk, not the old word
	assign op_rdata = op_done ? last : ~last;
endmodule // ecc_engine_model
